// *** sim/lccc_partner.sv ***
// nonvolatile configuration memory seen by the controller
`timescale 1ns/1ns
module lccc_partner (
    input wire logic clk,
    input wire logic nvmWrite,
    input wire logic [1:0] nvmWrCount,
    input wire logic nvmWrRestartLock,
    input wire logic nvmWrFeedback,
    input wire logic nvmWrConfigured,
    output logic [1:0] nvmCount,
    output logic nvmRestartLock,
    output logic nvmFeedback,
    output logic nvmConfigured
);
    // no reset input: contents must outlive a power cycle
    initial begin
        {nvmCount, nvmRestartLock, nvmFeedback, nvmConfigured} = 5'h00;
    end
    always @(posedge clk) begin
        if (nvmWrite) begin
            nvmCount <= nvmWrCount;
            nvmRestartLock <= nvmWrRestartLock;
            nvmFeedback <= nvmWrFeedback;
            nvmConfigured <= nvmWrConfigured;
        end
    end
endmodule

// *** sim/lccc_top_tb.sv ***
// self-checking bench for the configuration controller
`timescale 1ns/1ns
module lccc_top_tb
    import lccc_pkg::*;
();
    localparam int TK = 4;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, alignLed;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, nvmWrite, nvmWrRestartLock, nvmWrFeedback;
    logic [1:0] s_axi_bresp, s_axi_rresp, beamCode, nvmCount, nvmWrCount;
    logic [1:0] sw = 2'h0, cascadeFollowers = 2'h0;
    logic restartPushbuttonInput = 1'b0, contactorFeedbackCheck = 1'b0;
    logic neighbourRestartLock = 1'b0, neighbourFeedback = 1'b0;
    logic neighbourLock = 1'b0;
    logic [4:0] ledSeen;
    logic nvmRestartLock, nvmFeedback, nvmConfigured, nvmWrConfigured;
    logic factoryResetActive, configMode, lockOut, cascadeLockOut;
    logic restartLockOut, feedbackOut, fieldYellow, fieldGreen;
    logic auxStatusLampOutput, yPrev, mRl = 1'b0, mFb = 1'b0, mCf = 1'b0;
    int failCount = 0, checkCount = 0, yRise, stN = 0, seed = 32'h92c1;

    lccc_top #(.TICK_CYCLES(TK)) u_lccc_top (
        .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .codeSwitch1(sw[0]),
        .codeSwitch2(sw[1]), .restartPushbuttonInput,
        .contactorFeedbackCheck, .cascadeFollowers, .neighbourRestartLock,
        .neighbourFeedback, .neighbourLock, .nvmCount,
        .nvmRestartLock, .nvmFeedback, .nvmConfigured, .nvmWrite,
        .nvmWrCount, .nvmWrRestartLock, .nvmWrFeedback, .nvmWrConfigured,
        .beamCode, .factoryResetActive, .configMode, .lockOut,
        .cascadeLockOut, .restartLockOut, .feedbackOut, .fieldYellow,
        .fieldGreen, .alignLed, .auxStatusLampOutput);
    lccc_partner u_lccc_partner (.clk, .nvmWrite, .nvmWrCount,
        .nvmWrRestartLock, .nvmWrFeedback, .nvmWrConfigured, .nvmCount,
        .nvmRestartLock, .nvmFeedback, .nvmConfigured);

    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk or posedge reset) begin
        yRise <= reset ? 0 : yRise + int'(fieldYellow && !yPrev);
        yPrev <= fieldYellow;
        ledSeen <= reset ? 5'h00 : ledSeen | {fieldGreen, alignLed};
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checkCount++;
        if (s !== e) begin
            failCount++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic axw(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        logic awOpen = 1'b1, wOpen = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge clk);
            if (s_axi_awready) awOpen = 1'b0;
            if (s_axi_wready) wOpen = 1'b0;
            s_axi_awvalid <= awOpen;
            s_axi_wvalid <= wOpen;
        end while (awOpen || wOpen);
        while (!s_axi_bvalid) @(posedge clk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axr(logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    // power cycle, then compare against the reference boot decision
    task automatic boot(logic [1:0] c, logic f, logic [1:0] n, int wt);
        logic [31:0] d;
        logic [1:0] r;
        int st = 8;
        int oldN;
        reset <= 1'b1;
        sw <= c;
        contactorFeedbackCheck <= f;
        cascadeFollowers <= n;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        repeat (20 + wt) @(posedge clk);
        oldN = stN;
        if (c == 2'h3) begin
            st = 2;
            {mRl, mFb, mCf, stN} = 0;
        end else if ((mCf && n < stN) || n == 2'h3) begin
            st = 16;
        end else if (!mCf || n > stN || (f && !mFb)) begin
            st = 4;
            mRl = mRl | (!mCf & neighbourRestartLock);
            mFb = mFb | f | (!mCf & neighbourFeedback);
            stN = n;
            mCf = 1'b1;
        end
        axr(ADDR_STATUS, d, r);
        chk("state", st, d[8:4]);
        chk("pins", {st == 16, st == 16, st == 2},
            {lockOut, cascadeLockOut, factoryResetActive});
        if (st == 4 || st == 8) begin
            chk("flags", {mFb, mRl}, d[3:2]);
            chk("flagPins", {mFb, mRl},
                {feedbackOut, restartLockOut});
            if (wt > 0) chk("leds", {st == 4, mRl, stN == 2, stN != 0, mFb}
                & {5{st == 4}}, ledSeen);
            chk("code", c, beamCode);
            chk("stored", stN, nvmCount);
            if (wt > 0) chk("flashes", c, yRise);
        end
        @(posedge clk);
        axr(ADDR_CASCADE, d, r);
        chk("cascade", {oldN[1:0], 2'h0, n}, d[5:0]);
    endtask
    task automatic press(int ms);
        restartPushbuttonInput <= 1'b1;
        repeat (ms * TK) @(posedge clk);
        restartPushbuttonInput <= 1'b0;
        repeat (40 * TK) @(posedge clk);
    endtask
    task endOfTest;
        $display("checks %0d mismatches %0d", checkCount, failCount);
        if (failCount == 0 && checkCount > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int hi = 0;
        boot(2'h0, 1'b1, 2'h0, 0);
        d = $random(seed);
        axw(ADDR_CTRL, d, r);
        repeat (3) @(posedge clk);
        chk("lamp", d[0], auxStatusLampOutput);
        axr(8'hFC, d, r);
        chk("unmapped", RESP_SLVERR, r);
        press(3500);
        chk("longPress", 0, restartLockOut);
        press(1100 + $unsigned($random(seed)) % 1800);
        mRl = 1'b1;
        chk("lockSet", 3, {restartLockOut, configMode});
        axw(ADDR_CTRL, 32'h2, r);
        // lamp must both light and go dark while reset is required
        repeat (2500) @(posedge clk) hi += int'(auxStatusLampOutput);
        chk("blink", 1, hi > 0 && hi < 2500);
        boot(2'h1, 1'b0, 2'h2, 5000);
        boot(2'h2, 1'b0, 2'h2, 5000);
        boot(2'h0, 1'b0, 2'h1, 0);
        boot(2'h3, 1'b0, 2'h0, 0);
        chk("nvmClr", 0, {nvmRestartLock, nvmFeedback});
        repeat (10010 * TK) @(posedge clk);
        chk("factLock", 1, lockOut);
        boot(2'h0, 1'b0, 2'h3, 0);
        neighbourRestartLock <= 1'b1;
        neighbourFeedback <= 1'b1;
        boot(2'h0, 1'b0, 2'h0, 0);
        neighbourLock <= 1'b1;
        repeat (4) @(posedge clk);
        chk("nbLock", 3, {lockOut, cascadeLockOut});
        endOfTest();
    end
    initial begin
        repeat (100000) @(posedge clk);
        failCount++;
        endOfTest();
    end
endmodule

// *** verilog/lccc_debounce.sv ***
// pushbutton synchroniser and debouncer with edge pulses
`timescale 1ns/1ns
module lccc_debounce
    import lccc_pkg::*;
#(
    parameter int DB_MS = DEBOUNCE_MS
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic tickMs,
    input wire logic rawIn,
    output logic level,
    output logic rise,
    output logic fall
);
    initial begin
        if (DB_MS < 1 || DB_MS > 255) $error("DB_MS out of range");
    end
    logic sync1_r, sync2_r;
    logic [7:0] stable_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= rawIn;
            sync2_r <= sync1_r;
        end
    end
    // level only moves after the input held steady for DB_MS ticks
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stable_r <= 8'h00;
            level <= 1'b0;
            rise <= 1'b0;
            fall <= 1'b0;
        end else begin
            rise <= 1'b0;
            fall <= 1'b0;
            if (sync2_r == level) begin
                stable_r <= 8'h00;
            end else if (tickMs) begin
                if (stable_r == 8'(DB_MS - 1)) begin
                    level <= sync2_r;
                    rise <= sync2_r;
                    fall <= ~sync2_r;
                    stable_r <= 8'h00;
                end else begin
                    stable_r <= stable_r + 8'h01;
                end
            end
        end
    end
endmodule

// *** verilog/lccc_pkg.sv ***
// constants and types for the light curtain configuration controller
package lccc_pkg;
    localparam int CLK_HZ = 25_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int WINDOW_S = 30;
    localparam int FACT_S = 10;
    localparam int PRESS_MIN_S = 1;
    localparam int PRESS_MAX_S = 3;
    localparam int WINDOW_MS = WINDOW_S * 1000;
    localparam int FACT_MS = FACT_S * 1000;
    localparam int PRESS_MIN_MS = PRESS_MIN_S * 1000;
    localparam int PRESS_MAX_MS = PRESS_MAX_S * 1000;
    localparam int BLINK_MS = 250;
    localparam int DEBOUNCE_MS = 20;
    localparam int SETTLE_CYCLES = 4;
    localparam logic [1:0] MAX_FOLLOWERS = 2'h2;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_CASCADE = 8'h08;
    localparam int CTRL_WEAK = 0;
    localparam int CTRL_RESETREQ = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int ST_CODE_LSB = 0;
    localparam int ST_RL = 2;
    localparam int ST_FB = 3;
    localparam int ST_STATE_LSB = 4;
    localparam int CA_FOUND_LSB = 0;
    localparam int CA_STORED_LSB = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [4:0] {
        ST_BOOT = 5'h01,
        ST_FACT = 5'h02,
        ST_CFG = 5'h04,
        ST_RUN = 5'h08,
        ST_LOCK = 5'h10
    } lccc_state_t;
endpackage

// *** verilog/lccc_top.sv ***
// configuration controller: switches, restart lock, feedback, cascade
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module lccc_top
    import lccc_pkg::*;
#(
    parameter int TICK_CYCLES = MS_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic codeSwitch1,
    input wire logic codeSwitch2,
    input wire logic restartPushbuttonInput,
    input wire logic contactorFeedbackCheck,
    input wire logic [1:0] cascadeFollowers,
    input wire logic neighbourRestartLock,
    input wire logic neighbourFeedback,
    input wire logic neighbourLock,
    input wire logic [1:0] nvmCount,
    input wire logic nvmRestartLock,
    input wire logic nvmFeedback,
    input wire logic nvmConfigured,
    output logic nvmWrite,
    output logic [1:0] nvmWrCount,
    output logic nvmWrRestartLock,
    output logic nvmWrFeedback,
    output logic nvmWrConfigured,
    output logic [1:0] beamCode,
    output logic factoryResetActive,
    output logic configMode,
    output logic lockOut,
    output logic cascadeLockOut,
    output logic restartLockOut,
    output logic feedbackOut,
    output logic fieldYellow,
    output logic fieldGreen,
    output logic [3:0] alignLed,
    output logic auxStatusLampOutput
);
    initial begin
        if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
    end

    function automatic logic inCfgRun(lccc_state_t s);
        return (s == ST_CFG) || (s == ST_RUN);
    endfunction

    // pins from outside the clock domain
    logic [7:0] pin1_r, pin2_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin1_r <= 8'h00;
            pin2_r <= 8'h00;
        end else begin
            pin1_r <= {neighbourLock, neighbourFeedback, neighbourRestartLock,
                       cascadeFollowers, contactorFeedbackCheck,
                       codeSwitch2, codeSwitch1};
            pin2_r <= pin1_r;
        end
    end
    logic sw1, sw2, fbPin, nbRl, nbFb, nbLock;
    logic [1:0] found;
    assign sw1 = pin2_r[0];
    assign sw2 = pin2_r[1];
    assign fbPin = pin2_r[2];
    assign found = pin2_r[4:3];
    assign nbRl = pin2_r[5];
    assign nbFb = pin2_r[6];
    assign nbLock = pin2_r[7];

    // millisecond tick and time since power-on
    logic [15:0] divCnt_r;
    logic tickMs;
    logic [15:0] elapsedMs_r;
    logic [7:0] blinkCnt_r;
    logic blink_r, blinkTick;
    assign tickMs = (divCnt_r == 16'(TICK_CYCLES - 1));
    assign blinkTick = tickMs && (blinkCnt_r == 8'(BLINK_MS - 1));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divCnt_r <= 16'h0000;
        end else if (tickMs) begin
            divCnt_r <= 16'h0000;
        end else begin
            divCnt_r <= divCnt_r + 16'h0001;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            elapsedMs_r <= 16'h0000;
        end else if (tickMs && elapsedMs_r != 16'(WINDOW_MS)) begin
            elapsedMs_r <= elapsedMs_r + 16'h0001;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            blinkCnt_r <= 8'h00;
            blink_r <= 1'b0;
        end else if (blinkTick) begin
            blinkCnt_r <= 8'h00;
            blink_r <= ~blink_r;
        end else if (tickMs) begin
            blinkCnt_r <= blinkCnt_r + 8'h01;
        end
    end

    // pushbutton press timing
    logic btnLevel, btnRise, btnFall;
    lccc_debounce #(.DB_MS(DEBOUNCE_MS)) u_btn (
        .clk(clk),
        .reset(reset),
        .tickMs(tickMs),
        .rawIn(restartPushbuttonInput),
        .level(btnLevel),
        .rise(btnRise),
        .fall(btnFall)
    );
    logic [15:0] pressMs_r;
    logic startOk_r;
    logic windowOpen, pressOk;
    assign windowOpen = (elapsedMs_r < 16'(WINDOW_MS));
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pressMs_r <= 16'h0000;
            startOk_r <= 1'b0;
        end else if (btnRise) begin
            pressMs_r <= 16'h0000;
            startOk_r <= windowOpen;
        end else if (btnLevel && tickMs &&
                     pressMs_r <= 16'(PRESS_MAX_MS)) begin
            pressMs_r <= pressMs_r + 16'h0001;
        end
    end

    // configuration state
    lccc_state_t stateR, stateNxt;
    logic [2:0] bootCnt_r;
    logic rl_r, fb_r;
    logic [1:0] count_r, code_r, storedCnt_r;
    logic [3:0] codeFlash_r;
    logic newRl, newFb, changed, fewer;
    // a press of 1 s to 3 s, begun in the window, ends on release
    assign pressOk = btnFall && startOk_r && inCfgRun(stateR) && !rl_r &&
                     !nbLock &&
                     pressMs_r >= 16'(PRESS_MIN_MS) &&
                     pressMs_r <= 16'(PRESS_MAX_MS);
    // adoption only when this unit holds no stored configuration
    assign newRl = nvmRestartLock || (!nvmConfigured && nbRl);
    assign newFb = nvmFeedback || fbPin ||
                   (!nvmConfigured && nbFb);
    assign fewer = nvmConfigured && (found < nvmCount);
    assign changed = !nvmConfigured || (found > nvmCount) ||
                     (newFb != nvmFeedback) ||
                     (newRl != nvmRestartLock);

    always_comb begin
        stateNxt = stateR;
        case (stateR)
            ST_BOOT: begin
                if (bootCnt_r == 3'(SETTLE_CYCLES)) begin
                    if (sw1 && sw2) begin
                        stateNxt = ST_FACT;
                    end else if (nbLock || fewer ||
                                 found > MAX_FOLLOWERS) begin
                        stateNxt = ST_LOCK;
                    end else if (changed) begin
                        stateNxt = ST_CFG;
                    end else begin
                        stateNxt = ST_RUN;
                    end
                end
            end
            ST_FACT: begin
                if (elapsedMs_r >= 16'(FACT_MS)) begin
                    stateNxt = ST_LOCK;
                end
            end
            ST_CFG, ST_RUN: begin
                // leaving config needs a power cycle, i.e. reset, or nbLock, which forces ST_LOCK
                if (nbLock) begin
                    stateNxt = ST_LOCK;
                end else if (pressOk) begin
                    stateNxt = ST_CFG;
                end
            end
            ST_LOCK: begin
                stateNxt = ST_LOCK;
            end
            default: begin
                stateNxt = ST_LOCK;
            end
        endcase
    end

    logic bootExit;
    assign bootExit = (stateR == ST_BOOT) && (stateNxt != ST_BOOT);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stateR <= ST_BOOT;
            bootCnt_r <= 3'h0;
        end else begin
            stateR <= stateNxt;
            if (stateR == ST_BOOT) begin
                bootCnt_r <= bootCnt_r + 3'h1;
            end
        end
    end

    // delivered state until the stored settings are read at boot
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rl_r <= 1'b0;
            fb_r <= 1'b0;
            count_r <= 2'h0;
            storedCnt_r <= 2'h0;
            code_r <= 2'h0;
        end else if (bootExit) begin
            storedCnt_r <= nvmCount;
            count_r <= found;
            if (sw1 && sw2) begin
                code_r <= 2'h0;
            end else begin
                // coding is never stored, so each boot takes it afresh
                code_r <= {sw2, sw1};
                rl_r <= newRl;
                fb_r <= newFb;
            end
        end else if (pressOk) begin
            rl_r <= 1'b1;
        end
    end

    // nonvolatile write: defaults on factory reset, else new settings
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nvmWrite <= 1'b0;
            nvmWrCount <= 2'h0;
            nvmWrRestartLock <= 1'b0;
            nvmWrFeedback <= 1'b0;
            nvmWrConfigured <= 1'b0;
        end else begin
            nvmWrite <= 1'b0;
            if (bootExit && stateNxt == ST_FACT) begin
                nvmWrite <= 1'b1;
                nvmWrCount <= 2'h0;
                nvmWrRestartLock <= 1'b0;
                nvmWrFeedback <= 1'b0;
                nvmWrConfigured <= 1'b0;
            end else if (bootExit && stateNxt == ST_CFG) begin
                nvmWrite <= 1'b1;
                nvmWrCount <= found;
                nvmWrRestartLock <= newRl;
                nvmWrFeedback <= newFb;
                nvmWrConfigured <= 1'b1;
            end else if (pressOk) begin
                nvmWrite <= 1'b1;
                nvmWrCount <= count_r;
                nvmWrRestartLock <= 1'b1;
                nvmWrFeedback <= fb_r;
                nvmWrConfigured <= 1'b1;
            end
        end
    end

    // software control and indicators
    logic [31:0] ctrl_r;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            codeFlash_r <= 4'h0;
        end else if (bootExit && !(sw1 && sw2)) begin
            codeFlash_r <= {1'b0, sw2, sw1, 1'b0};
        end else if (blinkTick && codeFlash_r != 4'h0) begin
            codeFlash_r <= codeFlash_r - 4'h1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            fieldYellow <= 1'b0;
            fieldGreen <= 1'b0;
            alignLed <= 4'h0;
            auxStatusLampOutput <= 1'b0;
        end else begin
            fieldYellow <= 1'b0;
            fieldGreen <= 1'b0;
            alignLed <= 4'h0;
            case (stateR)
                ST_FACT: begin
                    fieldYellow <= blink_r;
                    fieldGreen <= ~blink_r;
                end
                ST_CFG: begin
                    fieldGreen <= blink_r;
                    fieldYellow <= codeFlash_r[0];
                    alignLed <= {rl_r, count_r == 2'h2, count_r != 2'h0,
                                 fb_r} & {4{blink_r}};
                end
                ST_RUN: begin
                    fieldYellow <= codeFlash_r[0];
                end
                default: begin
                    fieldYellow <= 1'b0;
                end
            endcase
            if (rl_r) begin
                auxStatusLampOutput <= ctrl_r[CTRL_RESETREQ] &
                                       blink_r;
            end else begin
                auxStatusLampOutput <= ctrl_r[CTRL_WEAK];
            end
        end
    end
    assign beamCode = code_r;
    assign factoryResetActive = (stateR == ST_FACT);
    assign configMode = (stateR == ST_CFG);
    assign lockOut = (stateR == ST_LOCK);
    assign cascadeLockOut = lockOut;
    assign restartLockOut = rl_r;
    assign feedbackOut = fb_r;

    // AXI4-Lite slave
    logic awHeld_r, wHeld_r;
    logic [7:0] awAddr_r;
    logic [31:0] wData_r;
    logic [3:0] wStrb_r;
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_r && !s_axi_bvalid;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awAddr_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            ctrl_r <= CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (awHeld_r && wHeld_r) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr_r == ADDR_CTRL) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (wStrb_r[0]) begin
                        ctrl_r[7:0] <= wData_r[7:0] & 8'h03;
                    end
                end else if (awAddr_r == ADDR_STATUS ||
                             awAddr_r == ADDR_CASCADE) begin
                    s_axi_bresp <= RESP_OKAY;
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr == ADDR_CTRL) begin
                s_axi_rdata <= ctrl_r;
            end else if (s_axi_araddr == ADDR_STATUS) begin
                s_axi_rdata[ST_CODE_LSB +: 2] <= code_r;
                s_axi_rdata[ST_RL] <= rl_r;
                s_axi_rdata[ST_FB] <= fb_r;
                s_axi_rdata[ST_STATE_LSB +: 5] <= stateR;
            end else if (s_axi_araddr == ADDR_CASCADE) begin
                s_axi_rdata[CA_FOUND_LSB +: 2] <= count_r;
                s_axi_rdata[CA_STORED_LSB +: 2] <= storedCnt_r;
            end else begin
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    AST_UNCODED: assert property (bootExit && !sw1 && !sw2 |=>
        beamCode == 2'h0) else $error("uncoded not selected");
    AST_CODE1: assert property (bootExit && sw1 && !sw2 |=>
        beamCode == 2'h1 ##1 beamCode == 2'h1)
        else $error("code 1 not selected");
    AST_CODE2: assert property (bootExit && !sw1 && sw2 |=>
        beamCode == 2'h2) else $error("code 2 not selected");
    AST_FACTORY: assert property (bootExit && sw1 && sw2 |=>
        factoryResetActive && nvmWrite && !nvmWrConfigured)
        else $error("factory reset not entered");
    AST_LATE_PRESS: assert property (btnFall && !startOk_r |=>
        $stable(rl_r)) else $error("late press configured");
    AST_LONG_PRESS: assert property (btnFall &&
        pressMs_r > 16'(PRESS_MAX_MS) |=> $stable(rl_r) && !nvmWrite)
        else $error("long press configured");
    AST_PRESS_CFG: assert property (pressOk |=> rl_r && configMode
        && nvmWrite && nvmWrRestartLock) else $error("press not taken");
    AST_LAMP_RL: assert property (rl_r && !ctrl_r[CTRL_RESETREQ]
        |=> !auxStatusLampOutput) else $error("lamp lit without need");
    AST_LAMP_WEAK: assert property (!rl_r && !$past(rl_r) &&
        ctrl_r[CTRL_WEAK] |=> auxStatusLampOutput)
        else $error("weak signal not shown");
    AST_FEWER: assert property (bootExit && fewer && !(sw1 && sw2) |=>
        lockOut && cascadeLockOut) else $error("missing unit not locked");
    AST_NB_LOCK: assert property (inCfgRun(stateR) && nbLock |=>
        lockOut) else $error("neighbour lock ignored");
    AST_FACT_TIME: assert property (factoryResetActive &&
        elapsedMs_r >= 16'(FACT_MS) |=> lockOut)
        else $error("factory timeout not locked");
    COV_CFG: cover property (bootExit && stateNxt == ST_CFG);
    COV_PRESS: cover property (pressOk);
    COV_LOCK: cover property ($rose(lockOut));
endmodule
